// ===== core/flt_pkg.sv
// Constants for the FIFO level, test and transmit length register block.
// Assumes one 25 MHz clock and a byte-wide register port from the host.
package flt_pkg;
  localparam logic [7:0] ADDR_TEST = 8'h1B;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_LENH = 8'h1D;
  localparam logic [7:0] ADDR_LENL = 8'h1E;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam int TB_FAST = 0;
  localparam int TB_DEC = 1;
  localparam int TB_IO0 = 2;
  localparam int TB_IO1 = 3;
  localparam int TB_RFLVL = 7;
  localparam int SB_HI = 6;
  localparam int SB_LO = 5;
  localparam int SB_OVF = 4;
  localparam int FIFO_DEPTH = 12;
  localparam logic [4:0] LVL_HIGH = 5'h09;
  localparam logic [4:0] LVL_LOW = 5'h03;
  localparam logic [4:0] LVL_FULL = 5'h0C;
  localparam int BUF_DEPTH = 2;
endpackage

// ===== core/flt_regs.sv
// Test, FIFO status and transmit length registers with a 12-byte FIFO.
// Assumes a host port that gives one-cycle write and read strobes.
`timescale 1ns/1ps
module flt_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic fifo_wr,
  input wire logic [7:0] fifo_wdata,
  input wire logic stop_cond,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic tx_eof_done,
  input wire logic rx_wr,
  input wire logic [7:0] rx_wdata,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic test_mode,
  output logic fast_coder_timing_select,
  output logic carrier_amplitude_check,
  output logic [11:0] frame_len,
  output logic [2:0] partial_bits,
  output logic partial_flag
);
  logic [7:0] test_q;
  logic [7:0] lenh_q;
  logic [7:0] lenl_q;
  logic mode_q;
  logic ovf_q;
  logic [7:0] mem_q [flt_pkg::FIFO_DEPTH];
  logic [3:0] wp_q;
  logic [3:0] rp_q;
  logic [4:0] cnt_q;
  logic [7:0] rdata_d;
  logic [7:0] stat_w;
  logic fifo_in;
  logic [7:0] fifo_in_data;
  logic push;
  logic pop;
  logic full;
  logic skid_ready;
  logic [7:0] skid_data;
  logic skid_valid;
  logic [2:0] pbits_d;
  logic host_fifo_wr;

  assign host_fifo_wr = fifo_wr && !rx_active;
  assign fifo_in = host_fifo_wr || rx_wr;
  assign fifo_in_data = rx_wr ? rx_wdata : fifo_wdata;
  assign full = (cnt_q == flt_pkg::LVL_FULL);
  assign push = fifo_in && !full;
  assign pop = (cnt_q != 5'h00) && skid_ready && !rx_active;

  // Test register; stop clears mode bits
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      test_q <= flt_pkg::RST_TEST;
    end else if (stop_cond) begin
      test_q[flt_pkg::TB_DEC] <= 1'b0;
      test_q[flt_pkg::TB_IO0] <= 1'b0;
      test_q[flt_pkg::TB_IO1] <= 1'b0;
    end else if (reg_wr && reg_addr == flt_pkg::ADDR_TEST) begin
      test_q <= reg_wdata;
    end
  end

  // Test mode latch
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      mode_q <= 1'b0;
    end else if (stop_cond) begin
      mode_q <= 1'b0;
    end else if (test_q[flt_pkg::TB_DEC] || test_q[flt_pkg::TB_IO0]
                 || test_q[flt_pkg::TB_IO1]) begin
      mode_q <= 1'b1;
    end
  end

  // Length registers
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      lenh_q <= flt_pkg::RST_LEN;
      lenl_q <= flt_pkg::RST_LEN;
    end else if (tx_eof_done) begin
      lenh_q <= flt_pkg::RST_LEN;
      lenl_q <= flt_pkg::RST_LEN;
    end else if (reg_wr) begin
      if (reg_addr == flt_pkg::ADDR_LENH) begin
        lenh_q <= reg_wdata;
      end else if (reg_addr == flt_pkg::ADDR_LENL) begin
        lenl_q <= reg_wdata;
      end
    end
  end

  // FIFO storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= fifo_in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (push) begin
        wp_q <= (wp_q == 4'hB) ? 4'h0 : 4'(wp_q + 4'h1);
      end
      if (pop) begin
        rp_q <= (rp_q == 4'hB) ? 4'h0 : 4'(rp_q + 4'h1);
      end
      cnt_q <= 5'(cnt_q + {4'h0, push} - {4'h0, pop});
    end
  end

  // Overflow sticky; set wins over the read clear
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      ovf_q <= 1'b0;
    end else if (host_fifo_wr && full) begin
      ovf_q <= 1'b1;
    end else if (reg_rd && reg_addr == flt_pkg::ADDR_STAT) begin
      ovf_q <= 1'b0;
    end
  end

  // Status word, read only
  always_comb begin
    stat_w = 8'h00;
    stat_w[flt_pkg::SB_HI] = rx_active && (cnt_q >= flt_pkg::LVL_HIGH);
    stat_w[flt_pkg::SB_LO] = tx_active && (cnt_q <= flt_pkg::LVL_LOW);
    stat_w[flt_pkg::SB_OVF] = ovf_q;
    stat_w[3:0] = (cnt_q == 5'h00) ? 4'h0 : 4'(cnt_q - 5'h01);
  end

  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == flt_pkg::ADDR_TEST) begin
      rdata_d = test_q;
    end else if (reg_addr == flt_pkg::ADDR_STAT) begin
      rdata_d = stat_w;
    end else if (reg_addr == flt_pkg::ADDR_LENH) begin
      rdata_d = lenh_q;
    end else if (reg_addr == flt_pkg::ADDR_LENL) begin
      rdata_d = lenl_q;
    end
  end

  // Partial count gated by flag
  always_comb begin
    pbits_d = lenl_q[0] ? lenl_q[3:1] : 3'h0;
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      test_mode <= 1'b0;
      fast_coder_timing_select <= 1'b0;
      carrier_amplitude_check <= 1'b0;
      frame_len <= 12'h000;
      partial_bits <= 3'h0;
      partial_flag <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      test_mode <= mode_q;
      fast_coder_timing_select <= test_q[flt_pkg::TB_FAST];
      carrier_amplitude_check <= test_q[flt_pkg::TB_RFLVL];
      frame_len <= {lenh_q, lenl_q[7:4]};
      partial_bits <= pbits_d;
      partial_flag <= lenl_q[0];
      tx_data <= skid_data;
      tx_valid <= skid_valid && tx_ready;
    end
  end

  flt_skid flt_skid_inst (
    .clk(clk),
    .nrst(nrst),
    .in_data(mem_q[rp_q]),
    .in_valid(pop),
    .in_ready(skid_ready),
    .out_data(skid_data),
    .out_valid(skid_valid),
    .out_ready(tx_ready)
  );

  // Test register and mode checks
  stop_clear_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && stop_cond |=> test_q[3:1] == 3'h0 && !mode_q)
    else $error("stop left test bits set");
  stop_keep_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && stop_cond |=> test_q[0] == $past(test_q[0])
    && test_q[7] == $past(test_q[7]))
    else $error("stop changed other test bits");
  reset_test_a: assert property (@(posedge clk)
    !nrst || !en |=> test_q == 8'h00 && lenh_q == 8'h00
    && lenl_q == 8'h00)
    else $error("test or length not zero after reset");
  test_wr_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !stop_cond && reg_wr && reg_addr == flt_pkg::ADDR_TEST
    |=> test_q == $past(reg_wdata))
    else $error("test register write lost");
  mode_enter_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !stop_cond && test_q[3:1] != 3'h0 |=> mode_q)
    else $error("test mode not entered");
  mode_idle_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !mode_q && test_q[3:1] == 3'h0 |=> !mode_q)
    else $error("test mode entered without a test bit");
  mode_hold_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && mode_q && !stop_cond |=> mode_q)
    else $error("test mode dropped without stop");
  // FIFO occupancy and overflow checks
  fifo_bound_a: assert property (@(posedge clk)
    disable iff (!nrst)
    cnt_q <= flt_pkg::LVL_FULL && wp_q <= 4'hB && rp_q <= 4'hB)
    else $error("FIFO count or pointer out of range");
  full_hold_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && full && !pop |=> cnt_q == flt_pkg::LVL_FULL)
    else $error("full FIFO took a byte");
  ovf_set_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && host_fifo_wr && full |=> ovf_q)
    else $error("overflow not flagged");
  ovf_clear_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !host_fifo_wr && reg_rd && reg_addr == flt_pkg::ADDR_STAT
    |=> !ovf_q)
    else $error("overflow not cleared by status read");
  ovf_keep_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !ovf_q && !host_fifo_wr |=> !ovf_q)
    else $error("overflow set without host write");
  en_clear_a: assert property (@(posedge clk)
    disable iff (!nrst)
    !en |=> cnt_q == 5'h00 && !ovf_q && !mode_q)
    else $error("enable low left FIFO or mode state");
  push_step_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && push && !pop |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("count missed a stored byte");
  pop_step_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && pop && !push |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("count missed a byte read out");
  rx_hold_a: assert property (@(posedge clk)
    disable iff (!nrst)
    rx_active |-> !pop)
    else $error("FIFO drained during reception");
  // Status word checks
  stat_rsvd_a: assert property (@(posedge clk)
    disable iff (!nrst)
    stat_w[7] == 1'b0)
    else $error("reserved status bit set");
  level_hi_a: assert property (@(posedge clk)
    disable iff (!nrst)
    rx_active && cnt_q == flt_pkg::LVL_HIGH
    |-> stat_w[flt_pkg::SB_HI] && stat_w[3:0] == 4'h8)
    else $error("high level or count wrong");
  hi_gate_a: assert property (@(posedge clk)
    disable iff (!nrst)
    !rx_active || cnt_q < flt_pkg::LVL_HIGH |-> !stat_w[flt_pkg::SB_HI])
    else $error("high level flag set too early");
  level_lo_a: assert property (@(posedge clk)
    disable iff (!nrst)
    tx_active && cnt_q == flt_pkg::LVL_LOW |-> stat_w[flt_pkg::SB_LO])
    else $error("low level wrong");
  lo_gate_a: assert property (@(posedge clk)
    disable iff (!nrst)
    !tx_active || cnt_q > flt_pkg::LVL_LOW |-> !stat_w[flt_pkg::SB_LO])
    else $error("low level flag set too early");
  count_field_a: assert property (@(posedge clk)
    disable iff (!nrst)
    cnt_q == 5'h08 |-> stat_w[3:0] == 4'h7)
    else $error("unread count not one less than held");
  stat_ro_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !stop_cond && !tx_eof_done && reg_wr
    && reg_addr == flt_pkg::ADDR_STAT |=> test_q == $past(test_q)
    && lenh_q == $past(lenh_q) && lenl_q == $past(lenl_q))
    else $error("status write changed a register");
  // Transmit length checks
  eof_clear_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && tx_eof_done |=> lenh_q == 8'h00 && lenl_q == 8'h00)
    else $error("length not cleared at end of frame");
  len_hold_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !tx_eof_done && !reg_wr
    |=> lenh_q == $past(lenh_q) && lenl_q == $past(lenl_q))
    else $error("length changed without a write");
  lenh_wr_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !tx_eof_done && reg_wr && reg_addr == flt_pkg::ADDR_LENH
    |=> lenh_q == $past(reg_wdata))
    else $error("high length write lost");
  lenl_wr_a: assert property (@(posedge clk)
    disable iff (!nrst)
    en && !tx_eof_done && reg_wr && reg_addr == flt_pkg::ADDR_LENL
    |=> lenl_q == $past(reg_wdata))
    else $error("low length write lost");
  // Registered output checks
  len_out_a: assert property (@(posedge clk)
    disable iff (!nrst)
    nrst |=> frame_len == $past({lenh_q, lenl_q[7:4]}))
    else $error("frame length mismatch");
  pbits_a: assert property (@(posedge clk)
    disable iff (!nrst)
    !lenl_q[0] |=> partial_bits == 3'h0)
    else $error("partial bits used without flag");
  pbits_flag_a: assert property (@(posedge clk)
    disable iff (!nrst)
    lenl_q[0] |=> partial_bits == $past(lenl_q[3:1]))
    else $error("partial bits lost with flag set");
  flag_out_a: assert property (@(posedge clk)
    disable iff (!nrst)
    nrst |=> partial_flag == $past(lenl_q[0]))
    else $error("partial flag output wrong");
  fast_out_a: assert property (@(posedge clk)
    disable iff (!nrst)
    nrst |=> fast_coder_timing_select == $past(test_q[flt_pkg::TB_FAST]))
    else $error("fast coder select output wrong");
  mode_out_a: assert property (@(posedge clk)
    disable iff (!nrst)
    nrst |=> test_mode == $past(mode_q))
    else $error("test mode output wrong");
  rd_rsvd_a: assert property (@(posedge clk)
    disable iff (!nrst)
    reg_addr == flt_pkg::ADDR_STAT |=> !reg_rdata[7])
    else $error("reserved status bit read as one");
  rd_unmap_a: assert property (@(posedge clk)
    disable iff (!nrst)
    reg_addr != flt_pkg::ADDR_TEST && reg_addr != flt_pkg::ADDR_STAT
    && reg_addr != flt_pkg::ADDR_LENH && reg_addr != flt_pkg::ADDR_LENL
    |=> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  tx_valid_a: assert property (@(posedge clk)
    disable iff (!nrst)
    tx_valid |-> $past(tx_ready))
    else $error("byte handed over without ready");

  cov_mode_c: cover property (@(posedge clk) mode_q ##[1:20] stop_cond);
  cov_ovf_c: cover property (@(posedge clk) host_fifo_wr && full);
  cov_eof_c: cover property (@(posedge clk) lenh_q != 8'h00 ##1 tx_eof_done);
  cov_stall_c: cover property (@(posedge clk) skid_valid && !tx_ready);
  cov_rxhi_c: cover property (@(posedge clk)
    rx_active && cnt_q == flt_pkg::LVL_HIGH);
endmodule

// ===== core/flt_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module flt_skid (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] mem_q [flt_pkg::BUF_DEPTH];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  a_never_over_a: assert property (@(posedge clk) disable iff (!nrst)
    cnt_q <= 2'h2) else $error("buffer count above two");
endmodule

// ===== test/fifo_level_tx_length_regs_test.sv
// Self-checking bench for the register block through its host port.
// Assumes a 25 MHz clock and the coder sink model at the buffer side.
`timescale 1ns/1ps
module fifo_level_tx_length_regs_test;
  logic clk, nrst, en, reg_wr, reg_rd, fifo_wr, stop_cond, go, slow;
  logic rx_active, tx_active, tx_eof_done, rx_wr, tx_valid, tx_ready;
  logic test_mode, fast_sel, amp_chk, partial_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_wdata, rx_wdata;
  logic [7:0] tx_data, rd;
  logic [11:0] frame_len;
  logic [2:0] partial_bits;
  int err_total, compares;
  flt_regs flt_regs_inst (.clk(clk), .nrst(nrst), .en(en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_wr(fifo_wr),
    .fifo_wdata(fifo_wdata), .stop_cond(stop_cond), .rx_active(rx_active),
    .tx_active(tx_active), .tx_eof_done(tx_eof_done), .rx_wr(rx_wr),
    .rx_wdata(rx_wdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .test_mode(test_mode),
    .fast_coder_timing_select(fast_sel), .carrier_amplitude_check(amp_chk),
    .frame_len(frame_len), .partial_bits(partial_bits),
    .partial_flag(partial_flag));
  flt_coder_model flt_coder_model_inst (.clk(clk), .go(go), .slow(slow),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] s, e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdv(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    rd = reg_rdata;
    reg_rd = 1'b0;
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    rdv(a);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic stop_pulse();
    stop_cond = 1'b1;
    tick(1);
    stop_cond = 1'b0;
    tick(3);
  endtask
  task automatic summarize();
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    err_total++;
    summarize();
  end
  initial begin
    {nrst, reg_wr, reg_rd, fifo_wr, stop_cond, go, slow} = '0;
    {rx_active, tx_active, tx_eof_done, rx_wr} = '0;
    {reg_addr, reg_wdata, fifo_wdata, rx_wdata} = '0;
    en = 1'b1;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    rdc(8'h1B, 8'h00);
    rdc(8'h1C, 8'h00);
    rdc(8'h1D, 8'h00);
    rdc(8'h1E, 8'h00);
    rdc(8'h1F, 8'h00);
    // Each test-mode source alone, ended by a stop condition
    for (int i = 0; i < 3; i++) begin
      wr(8'h1B, 8'h02 << i);
      tick(3);
      chk("test_mode", test_mode, 1'b1);
      stop_pulse();
      chk("test_mode", test_mode, 1'b0);
      rdc(8'h1B, 8'h00);
    end
    wr(8'h1B, 8'h02);
    wr(8'h1B, 8'h81);
    tick(3);
    chk("test_mode", test_mode, 1'b1);
    chk("fast_sel", fast_sel, 1'b1);
    chk("amp_chk", amp_chk, 1'b1);
    stop_pulse();
    chk("test_mode", test_mode, 1'b0);
    rdc(8'h1B, 8'h81);
    // Overflow with the coder stalled, then drain
    for (int i = 0; i < 16; i++) begin
      fifo_wr = 1'b1;
      fifo_wdata = 8'(8'hA0 + i);
      tick(1);
    end
    fifo_wr = 1'b0;
    tick(3);
    rdv(8'h1C);
    chk("ovf", rd[4], 1'b1);
    rdv(8'h1C);
    chk("ovf", rd[4], 1'b0);
    tx_active = 1'b1;
    go = 1'b1;
    slow = 1'b1;
    tick(80);
    chk("count", flt_coder_model_inst.got.size() >= 12, 1'b1);
    for (int i = 0; i < 12; i++)
      chk("byte", flt_coder_model_inst.got[i], 12'(8'hA0 + i));
    rdc(8'h1C, 8'h20);
    wr(8'h1C, 8'hFF);
    rdc(8'h1C, 8'h20);
    tx_active = 1'b0;
    en = 1'b0;
    tick(1);
    en = 1'b1;
    // Reception levels, eight then nine bytes held
    rx_active = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rx_wr = 1'b1;
      rx_wdata = 8'(8'h30 + i);
      tick(1);
      if (i == 7) begin
        rx_wr = 1'b0;
        tick(3);
        rdc(8'h1C, 8'h07);
      end
    end
    rx_wr = 1'b0;
    tick(3);
    rdc(8'h1C, 8'h48);
    rx_active = 1'b0;
    // Lengths written, then cleared at end of frame and by enable low
    wr(8'h1D, 8'hA5);
    wr(8'h1E, 8'h3B);
    tick(2);
    chk("frame_len", frame_len, 12'hA53);
    chk("partial_bits", partial_bits, 3'h5);
    chk("partial_flag", partial_flag, 1'b1);
    rdc(8'h1D, 8'hA5);
    rdc(8'h1E, 8'h3B);
    wr(8'h1E, 8'h3A);
    tick(2);
    chk("partial_bits", partial_bits, 3'h0);
    chk("partial_flag", partial_flag, 1'b0);
    tx_eof_done = 1'b1;
    tick(1);
    tx_eof_done = 1'b0;
    tick(2);
    rdc(8'h1D, 8'h00);
    rdc(8'h1E, 8'h00);
    chk("frame_len", frame_len, 12'h000);
    wr(8'h1D, 8'hFF);
    wr(8'h1B, 8'h01);
    en = 1'b0;
    tick(1);
    en = 1'b1;
    tick(1);
    rdc(8'h1B, 8'h00);
    rdc(8'h1D, 8'h00);
    summarize();
  end
endmodule

// ===== test/flt_coder_model.sv
// Coder-side sink that takes bytes from the transmit buffer.
// Assumes the block's tx_valid marks each byte handed over.
`timescale 1ns/1ps
module flt_coder_model (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic ph;
  initial begin
    ph = 1'b0;
    tx_ready = 1'b0;
  end
  // Stalls while go is low, every other cycle when slow
  always @(posedge clk) begin
    if (tx_valid === 1'b1) got.push_back(tx_data);
    ph <= ~ph;
    tx_ready <= #1 go && (!slow || ph);
  end
endmodule
